// ==== design/pfm_blink.sv ====
`timescale 1ns/1ps
module pfm_blink (
    input  wire logic  clk_sys, // System clock
    input  wire logic  nrst,    // Async reset, active low
    input  wire logic  ce,      // Clock enable
    pfm_led_if.blk     led      // Pattern request and lamp state
);
    pfm_pkg::pfm_mode_e mode_q;
    pfm_pkg::pfm_bst_e  st_q, st_d;
    logic [11:0]        ms_q, ms_d;
    logic [3:0]         rep_q, rep_d;
    logic               on_q, on_d;
    logic [11:0]        on_len, off_len, pause_len, seg_len;
    logic [3:0]         reps;

    // Pattern shape per mode
    always_comb begin
        on_len    = 12'(pfm_pkg::BLINK_ON_MS);
        off_len   = 12'(pfm_pkg::BLINK_OFF_MS);
        pause_len = 12'(pfm_pkg::SOL_PAUSE_MS);
        reps      = 4'h1;
        case (led.mode)
            pfm_pkg::M_SOL: begin
                reps = led.sol_num;
            end
            pfm_pkg::M_COMP: begin
                // One flash per period, the rest dark
                pause_len = 12'(pfm_pkg::COMP_PERIOD_MS
                                - pfm_pkg::BLINK_ON_MS);
            end
            pfm_pkg::M_STICKY: begin
                on_len    = 12'(pfm_pkg::STICKY_HALF_MS);
                pause_len = 12'(pfm_pkg::STICKY_HALF_MS);
            end
            default: begin
                reps = 4'h1;
            end
        endcase
        case (st_q)
            pfm_pkg::S_ON:  seg_len = on_len;
            pfm_pkg::S_OFF: seg_len = off_len;
            default:        seg_len = pause_len;
        endcase
    end

    // Sequencer; a mode change restarts the pattern from its first flash
    always_comb begin
        st_d  = st_q;
        ms_d  = ms_q;
        rep_d = rep_q;
        if (led.mode != mode_q) begin
            st_d  = pfm_pkg::S_ON;
            ms_d  = 12'h000;
            rep_d = 4'h0;
        end else if (led.tick) begin
            ms_d = ms_q + 12'h001;
            if (ms_q + 12'h001 >= seg_len) begin
                ms_d = 12'h000;
                case (st_q)
                    pfm_pkg::S_ON: begin
                        if (rep_q + 4'h1 >= reps) begin
                            st_d = pfm_pkg::S_PAUSE;
                        end else begin
                            st_d = pfm_pkg::S_OFF;
                        end
                    end
                    pfm_pkg::S_OFF: begin
                        st_d  = pfm_pkg::S_ON;
                        rep_d = rep_q + 4'h1;
                    end
                    default: begin
                        st_d  = pfm_pkg::S_ON;
                        rep_d = 4'h0;
                    end
                endcase
            end
        end
        // Healthy unit shows a steady lamp
        on_d = (st_d == pfm_pkg::S_ON) || (led.mode == pfm_pkg::M_OK);
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_q <= pfm_pkg::M_OK;
            st_q   <= pfm_pkg::S_ON;
            ms_q   <= 12'h000;
            rep_q  <= 4'h0;
            on_q   <= 1'b0;
        end else if (ce) begin
            mode_q <= led.mode;
            st_q   <= st_d;
            ms_q   <= ms_d;
            rep_q  <= rep_d;
            on_q   <= on_d;
        end
    end

    assign led.led_on = on_q;

    chk_sol_flash_count: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_q == pfm_pkg::S_OFF && mode_q == pfm_pkg::M_SOL)
        |-> (rep_q + 4'h1 < led.sol_num))
        else $error("solenoid flash count exceeded");

    chk_comp_one_flash: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (mode_q == pfm_pkg::M_COMP && led.mode == pfm_pkg::M_COMP)
        |-> (st_q != pfm_pkg::S_OFF
             && ms_q < 12'(pfm_pkg::COMP_PERIOD_MS
                           - pfm_pkg::BLINK_ON_MS)))
        else $error("compressor pattern out of shape");

endmodule

// ==== design/pfm_led_if.sv ====
`timescale 1ns/1ps
interface pfm_led_if;
    logic                tick;
    pfm_pkg::pfm_mode_e  mode;
    logic [3:0]          sol_num;
    logic                led_on;

    modport ctl (output tick, output mode, output sol_num, input led_on);
    modport blk (input tick, input mode, input sol_num, output led_on);
endinterface

// ==== design/pfm_pkg.sv ====
package pfm_pkg;

    // Register byte offsets
    localparam logic [7:0] A_LIVE   = 8'h00;
    localparam logic [7:0] A_STICKY = 8'h04;
    localparam logic [7:0] A_CLEAR  = 8'h08;
    localparam logic [7:0] A_ISTAT  = 8'h0c;
    localparam logic [7:0] A_IMASK  = 8'h10;
    localparam logic [7:0] A_STATE  = 8'h14;

    // Fault bit positions, shared by live, sticky and interrupt layouts
    localparam int B_COMP  = 0;
    localparam int B_SOL   = 1;
    localparam int B_RSTEN = 2;
    localparam int B_CLRD  = 3;
    localparam int NV_B_EN = 3;
    localparam int LIVE_NUM_LSB = 4;

    // Reset values
    localparam logic [2:0] STICKY_RST = 3'h0;
    localparam logic [3:0] IMASK_RST  = 4'h0;
    localparam logic [3:0] ISTAT_RST  = 4'h0;

    localparam int N_SOL = 8;

    // Timing: a millisecond tick, all fault timing counts ticks
    localparam int CLK_MHZ  = 125;
    localparam int TICK_US  = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int RETRY_MS       = 5000;
    localparam int COMP_OK_MS     = 100;
    localparam int COMP_PERIOD_MS = 2000;
    localparam int BLINK_ON_MS    = 250;
    localparam int BLINK_OFF_MS   = 250;
    localparam int SOL_PAUSE_MS   = 1000;
    localparam int STICKY_HALF_MS = 1000;
    localparam int CNT_W = 13;

    typedef enum logic [3:0] {
        M_OK     = 4'h1,
        M_STICKY = 4'h2,
        M_COMP   = 4'h4,
        M_SOL    = 4'h8
    } pfm_mode_e;

    typedef enum logic [2:0] {
        C_IDLE = 3'h1,
        C_RUN  = 3'h2,
        C_WAIT = 3'h4
    } pfm_cst_e;

    typedef enum logic [2:0] {
        S_ON    = 3'h1,
        S_OFF   = 3'h2,
        S_PAUSE = 3'h4
    } pfm_bst_e;

endpackage

// ==== design/pfm_top.sv ====
`timescale 1ns/1ps
module pfm_top #(
    parameter int TICK_CYC = pfm_pkg::TICK_CYC // Cycles per millisecond
) (
    input  wire logic        clk_sys,     // System clock, 125 MHz
    input  wire logic        nrst,        // Async reset, active low
    input  wire logic        ce,          // Clock enable, freezes state
    input  wire logic [7:0]  addr,        // Register byte address
    input  wire logic [31:0] wdata,       // Register write data
    input  wire logic        wr,          // Write strobe
    input  wire logic        rd,          // Read strobe
    output logic      [31:0] rdata,       // Read data, cycle after rd
    input  wire logic        can_clr,     // Clear command from CAN link
    input  wire logic        robot_en,    // Robot enabled, from CAN link
    input  wire logic [7:0]  sol_flt_pin, // Solenoid driver fault pins
    input  wire logic        comp_oc_pin, // Compressor overcurrent pin
    input  wire logic        comp_req,    // Pressure logic wants air
    output logic             comp_en,     // Compressor drive enable
    output logic             led_red,     // Red lamp
    output logic             led_green,   // Green lamp
    input  wire logic [3:0]  nv_rdata,    // Stored fault image at boot
    output logic      [3:0]  nv_wdata,    // Fault image to store
    output logic             nv_we,       // Store strobe
    output logic             irq          // Interrupt, active high level
);
    localparam int TW = $clog2(TICK_CYC);

    pfm_led_if led_if ();

    // Pin synchronisers; first stage feeds only the second
    logic [pfm_pkg::N_SOL-1:0] sol_s1_q, sol_s2_q;
    logic                      oc_s1_q, oc_s2_q;

    genvar gi;
    generate
        for (gi = 0; gi < pfm_pkg::N_SOL; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    sol_s1_q[gi] <= 1'b0;
                    sol_s2_q[gi] <= 1'b0;
                end else if (ce) begin
                    sol_s1_q[gi] <= sol_flt_pin[gi];
                    sol_s2_q[gi] <= sol_s1_q[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            oc_s1_q <= 1'b0;
            oc_s2_q <= 1'b0;
        end else if (ce) begin
            oc_s1_q <= comp_oc_pin;
            oc_s2_q <= oc_s1_q;
        end
    end

    // Millisecond tick keeps every fault timer narrow
    logic [TW-1:0] tdiv_q, tdiv_d;
    logic          tick;

    always_comb begin
        tick   = (tdiv_q == TW'(TICK_CYC - 1));
        tdiv_d = tick ? '0 : tdiv_q + TW'(1);
    end

    // Solenoid fault latches with the lowest faulted number, 1-based
    logic       sol_live_q, sol_live_d;
    logic [3:0] sol_num_q, sol_num_d;

    always_comb begin
        sol_live_d = sol_live_q | (|sol_s2_q);
        sol_num_d  = sol_num_q;
        if (!sol_live_q) begin
            for (int i = pfm_pkg::N_SOL - 1; i >= 0; i--) begin
                if (sol_s2_q[i]) begin
                    sol_num_d = 4'(i + 1);
                end
            end
        end
    end

    // Compressor run, fault and retry control
    pfm_pkg::pfm_cst_e         cst_q, cst_d;
    logic [pfm_pkg::CNT_W-1:0] ccnt_q, ccnt_d;
    logic                      comp_live_q, comp_live_d;
    logic                      comp_en_q, comp_en_d;

    always_comb begin
        cst_d       = cst_q;
        ccnt_d      = ccnt_q;
        comp_live_d = comp_live_q;
        comp_en_d   = 1'b0;
        case (cst_q)
            pfm_pkg::C_IDLE: begin
                // Sticky state plays no part in starting a run
                if (comp_req) begin
                    cst_d     = pfm_pkg::C_RUN;
                    ccnt_d    = '0;
                    comp_en_d = 1'b1;
                end
            end
            pfm_pkg::C_RUN: begin
                comp_en_d = 1'b1;
                if (oc_s2_q) begin
                    comp_live_d = 1'b1;
                    cst_d       = pfm_pkg::C_WAIT;
                    ccnt_d      = pfm_pkg::CNT_W'(pfm_pkg::RETRY_MS);
                    comp_en_d   = 1'b0;
                end else if (!comp_req) begin
                    cst_d     = pfm_pkg::C_IDLE;
                    comp_en_d = 1'b0;
                end else if (tick && comp_live_q) begin
                    // A run that stays clean long enough ends the fault
                    if (ccnt_q + 1'b1 >= pfm_pkg::CNT_W'(pfm_pkg::COMP_OK_MS))
                    begin
                        comp_live_d = 1'b0;
                    end else begin
                        ccnt_d = ccnt_q + 1'b1;
                    end
                end
            end
            pfm_pkg::C_WAIT: begin
                // Extra tick covers the partial first millisecond
                if (tick) begin
                    if (ccnt_q == '0) begin
                        cst_d = pfm_pkg::C_IDLE;
                    end else begin
                        ccnt_d = ccnt_q - 1'b1;
                    end
                end
            end
            default: begin
                cst_d = pfm_pkg::C_IDLE;
            end
        endcase
    end

    // Sticky flags, boot restore and nonvolatile image
    logic       boot_q, boot_d;
    logic       en_q;
    logic [2:0] sticky_q, sticky_d, live_now;
    logic [3:0] img_q, img_d;
    logic       nv_we_q, nv_we_d;
    logic       clr;

    always_comb begin
        clr      = can_clr
                 | (wr && addr == pfm_pkg::A_CLEAR && wdata[0]);
        live_now = 3'h0;
        live_now[pfm_pkg::B_COMP] = comp_live_d;
        live_now[pfm_pkg::B_SOL]  = sol_live_d;
        // Set beats clear; a fault still present keeps its bit
        sticky_d = live_now | (clr ? 3'h0 : sticky_q);
        boot_d   = 1'b0;
        if (boot_q) begin
            sticky_d = sticky_d | nv_rdata[2:0];
            if (nv_rdata[pfm_pkg::NV_B_EN]) begin
                sticky_d[pfm_pkg::B_RSTEN] = 1'b1;
            end
        end
        img_d   = {robot_en, sticky_d};
        // Image written on change only, to spare storage endurance
        nv_we_d = !boot_q && (img_d != img_q);
    end

    // Interrupt status and mask
    logic [3:0] istat_q, istat_d, imask_q, imask_d, ev;

    always_comb begin
        ev = 4'h0;
        ev[pfm_pkg::B_COMP]  = comp_live_d & ~comp_live_q;
        ev[pfm_pkg::B_SOL]   = sol_live_d & ~sol_live_q;
        ev[pfm_pkg::B_RSTEN] = sticky_d[pfm_pkg::B_RSTEN]
                             & ~sticky_q[pfm_pkg::B_RSTEN];
        ev[pfm_pkg::B_CLRD]  = clr;
        istat_d = istat_q;
        imask_d = imask_q;
        if (wr && addr == pfm_pkg::A_ISTAT) begin
            istat_d = istat_q & ~wdata[3:0];
        end
        if (wr && addr == pfm_pkg::A_IMASK) begin
            imask_d = wdata[3:0];
        end
        istat_d = istat_d | ev; // New event wins over its clear
    end

    // Read mux; unmapped addresses read zero
    logic [31:0] rdata_q, rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (rd) begin
            case (addr)
                pfm_pkg::A_LIVE:   rdata_d = {24'h000000, sol_num_q,
                                              2'b00, sol_live_q,
                                              comp_live_q};
                pfm_pkg::A_STICKY: rdata_d = {29'h00000000, sticky_q};
                pfm_pkg::A_ISTAT:  rdata_d = {28'h0000000, istat_q};
                pfm_pkg::A_IMASK:  rdata_d = {28'h0000000, imask_q};
                pfm_pkg::A_STATE:  rdata_d = {27'h0000000, comp_en_q,
                                              en_q, cst_q};
                default:           rdata_d = 32'h00000000;
            endcase
        end
    end

    // Lamp mode by priority, solenoid first
    logic led_red_q, led_green_q;

    always_comb begin
        led_if.tick    = tick;
        led_if.sol_num = sol_num_q;
        if (sol_live_q) begin
            led_if.mode = pfm_pkg::M_SOL;
        end else if (comp_live_q) begin
            led_if.mode = pfm_pkg::M_COMP;
        end else if (|sticky_q) begin
            led_if.mode = pfm_pkg::M_STICKY;
        end else begin
            led_if.mode = pfm_pkg::M_OK;
        end
    end

    pfm_blink u_blink (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .led     (led_if.blk)
    );

    // All state registers but the pin synchronisers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tdiv_q      <= '0;
            sol_live_q  <= 1'b0;
            sol_num_q   <= 4'h0;
            cst_q       <= pfm_pkg::C_IDLE;
            ccnt_q      <= '0;
            comp_live_q <= 1'b0;
            comp_en_q   <= 1'b0;
            boot_q      <= 1'b1;
            en_q        <= 1'b0;
            sticky_q    <= pfm_pkg::STICKY_RST;
            img_q       <= 4'h0;
            nv_we_q     <= 1'b0;
            istat_q     <= pfm_pkg::ISTAT_RST;
            imask_q     <= pfm_pkg::IMASK_RST;
            rdata_q     <= 32'h00000000;
            led_red_q   <= 1'b0;
            led_green_q <= 1'b0;
        end else if (ce) begin
            tdiv_q      <= tdiv_d;
            sol_live_q  <= sol_live_d;
            sol_num_q   <= sol_num_d;
            cst_q       <= cst_d;
            ccnt_q      <= ccnt_d;
            comp_live_q <= comp_live_d;
            comp_en_q   <= comp_en_d;
            boot_q      <= boot_d;
            en_q        <= robot_en;
            sticky_q    <= sticky_d;
            img_q       <= img_d;
            nv_we_q     <= nv_we_d;
            istat_q     <= istat_d;
            imask_q     <= imask_d;
            rdata_q     <= rdata_d;
            led_red_q   <= led_if.led_on
                         & (led_if.mode != pfm_pkg::M_OK);
            led_green_q <= led_if.led_on
                         & (led_if.mode == pfm_pkg::M_OK
                            || led_if.mode == pfm_pkg::M_STICKY);
        end
    end

    assign rdata     = rdata_q;
    assign comp_en   = comp_en_q;
    assign led_red   = led_red_q;
    assign led_green = led_green_q;
    assign nv_wdata  = img_q;
    assign nv_we     = nv_we_q;
    assign irq       = |(istat_q & imask_q);

    chk_sticky_same_cycle: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && comp_live_d) |=> (comp_live_q && sticky_q[0]))
        else $error("sticky did not follow live fault");

    chk_sticky_holds: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && sticky_q[1] && !clr) |=> sticky_q[1])
        else $error("sticky flag dropped without clear");

    chk_clear_by_cmd: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(sticky_q[0]) |-> $past(clr && !comp_live_d))
        else $error("sticky cleared without command");

    chk_sol_live_kept: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        sol_live_q |=> sol_live_q)
        else $error("solenoid fault cleared before power-up");

    chk_retry_blocked: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && oc_s2_q && cst_q == pfm_pkg::C_RUN)
        |=> (!comp_en_q && comp_live_q) ##1 !comp_en_q [*8])
        else $error("compressor not held off after fault");

    chk_comp_clear_run: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $fell(comp_live_q) |-> $past(cst_q == pfm_pkg::C_RUN && tick))
        else $error("compressor fault cleared outside a clean run");

    chk_flags_no_effect: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && cst_q == pfm_pkg::C_IDLE && comp_req) |=> comp_en_q)
        else $error("run start blocked");

    chk_reset_while_en: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && boot_q && nv_rdata[3]) |=> sticky_q[2])
        else $error("reset-while-enabled flag missing");

    chk_nv_store: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ce && !boot_q && sticky_d != sticky_q)
        |=> (nv_we && nv_wdata[2:0] == sticky_q))
        else $error("sticky change not stored");

endmodule

// ==== tb/pfm_host_model.sv ====
`timescale 1ns/1ps
// Stand-in for the CAN host: sends clear commands, reports robot enable
module pfm_host_model (
    input  wire logic clk_sys,  // System clock
    output logic      can_clr,  // One-cycle clear command
    output logic      robot_en  // Robot enabled level
);
    initial begin
        can_clr = 1'b0;
        robot_en = 1'b0;
    end

    // Clear is a single pulse; a held level would look like many clears
    task automatic send_clear();
        @(posedge clk_sys);
        can_clr <= 1'b1;
        @(posedge clk_sys);
        can_clr <= 1'b0;
    endtask

    // Enable changes only right after an edge
    task automatic set_enable(input logic en);
        @(posedge clk_sys);
        robot_en <= en;
    endtask
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    localparam int TK = 5; // Short tick keeps the run small
    logic        clk_sys, nrst, wr, rd, comp_oc_pin, comp_req;
    logic        can_clr, robot_en, comp_en, led_red, led_green, nv_we;
    logic        irq;
    logic [7:0]  addr, sol_flt_pin;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  nv_rdata, nv_wdata;
    int          bad_count, checks, cyc, k, t;

    pfm_host_model host (.clk_sys(clk_sys), .can_clr(can_clr),
                         .robot_en(robot_en));

    pfm_top #(.TICK_CYC(TK)) DUT (
        .clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .can_clr(can_clr), .robot_en(robot_en),
        .sol_flt_pin(sol_flt_pin), .comp_oc_pin(comp_oc_pin),
        .comp_req(comp_req), .comp_en(comp_en), .led_red(led_red),
        .led_green(led_green), .nv_rdata(nv_rdata),
        .nv_wdata(nv_wdata), .nv_we(nv_we), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // Read data is looked at only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a,
                          input logic [31:0] e);
        rd_reg(a, v);
        chk(n, v, e);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    // Counts red lamp rising edges over n cycles
    task automatic count_red(input int n, output int c);
        logic p;
        p = led_red;
        c = 0;
        repeat (n) begin
            @(posedge clk_sys);
            #1 if (led_red && !p) c++;
            p = led_red;
        end
    endtask

    initial begin
        {wr, rd, comp_oc_pin, comp_req} = '0;
        {addr, wdata, sol_flt_pin, nv_rdata} = '0;
        {bad_count, checks, cyc} = '0;
        nrst = 1'b0;
        do_reset();
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h0);
        rd_chk("imask", pfm_pkg::A_IMASK, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        $display("test reset done");

        wr_reg(pfm_pkg::A_IMASK, 32'h1);
        comp_req <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 chk("comp_en", comp_en, 1'b1);
        @(posedge clk_sys);
        comp_oc_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 chk("comp_en", comp_en, 1'b0);
        rd_chk("state", pfm_pkg::A_STATE, 32'h4);
        rd_chk("live", pfm_pkg::A_LIVE, 32'h1);
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h1);
        chk("irq", irq, 1'b1);
        wr_reg(pfm_pkg::A_ISTAT, 32'h1);
        @(posedge clk_sys);
        comp_oc_pin <= 1'b0;
        #1 chk("irq", irq, 1'b0);
        count_red(20000, k);
        chk("comp blinks", k, 2);
        t = 20000;
        while (comp_en !== 1'b1 && t < 26000) begin
            @(posedge clk_sys);
            #1 t++;
        end
        chk("retry early", t >= pfm_pkg::RETRY_MS * TK - 20, 1'b1);
        chk("retry late", t <= (pfm_pkg::RETRY_MS + 1) * TK + 20, 1'b1);
        repeat (pfm_pkg::COMP_OK_MS * TK + 20) @(posedge clk_sys);
        rd_chk("live", pfm_pkg::A_LIVE, 32'h0);
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h1);
        chk("comp_en", comp_en, 1'b1);
        rd_chk("state", pfm_pkg::A_STATE, 32'h12);
        t = 0;
        while (!(led_red && led_green) && t < 2000 * TK + 20) begin
            @(posedge clk_sys);
            #1 t++;
        end
        chk("orange", led_red & led_green, 1'b1);
        host.send_clear();
        @(posedge clk_sys);
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h0);
        rd_chk("istat", pfm_pkg::A_ISTAT, 32'h8);
        chk("irq", irq, 1'b0);
        $display("test compressor done");

        // Pins 2 and 5 fault: lowest index plus one is three
        @(posedge clk_sys);
        sol_flt_pin <= 8'h24;
        repeat (6) @(posedge clk_sys);
        rd_chk("live", pfm_pkg::A_LIVE, 32'h32);
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h2);
        // First flash is lit already; window ends past a third flash but
        // before the next burst, so a wrong flash count shows
        chk("sol flash", led_red, 1'b1);
        count_red(1600 * TK, k);
        chk("sol blinks", k, 2);
        wr_reg(pfm_pkg::A_CLEAR, 32'h1);
        sol_flt_pin <= 8'h00;
        repeat (6) @(posedge clk_sys);
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h2);
        rd_chk("live", pfm_pkg::A_LIVE, 32'h32);
        $display("test solenoid done");

        host.set_enable(1'b1);
        @(posedge clk_sys);
        #1 chk("nv store", nv_we, 1'b1);
        repeat (5) @(posedge clk_sys);
        nv_rdata <= 4'ha; // Image kept by the store across power loss
        #1 chk("nv image", nv_wdata, 4'ha);
        do_reset();
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h6);
        rd_chk("live", pfm_pkg::A_LIVE, 32'h0);
        host.send_clear();
        @(posedge clk_sys);
        rd_chk("sticky", pfm_pkg::A_STICKY, 32'h0);
        $display("test power cycle done");
        give_verdict();
    end
endmodule
